// File: logic/sli_pkg.sv
package sli_pkg;

    // ==========================================
    // Clock and pattern timing.
    localparam int CLK_HZ = 125_000_000;
    localparam int CYC_PER_MS = CLK_HZ / 1000;
    localparam int PHASE_MS = 200;
    localparam int PAUSE_MS = 1000;
    localparam int FLICK_MS = 50;
    localparam int PHASE_CYC = PHASE_MS * CYC_PER_MS;
    localparam int FLICK_CYC = FLICK_MS * CYC_PER_MS;
    localparam int PAUSE_SLOTS = PAUSE_MS / PHASE_MS;
    localparam int SINGLE_SLOTS = 1 + PAUSE_SLOTS;
    localparam int DOUBLE_SLOTS = 3 + PAUSE_SLOTS;

    // ==========================================
    // Fieldbus slave state codes on the state input.
    localparam logic [2:0] FB_INIT = 3'h0;
    localparam logic [2:0] FB_PREOP = 3'h1;
    localparam logic [2:0] FB_SAFEOP = 3'h2;
    localparam logic [2:0] FB_BOOT = 3'h3;
    localparam logic [2:0] FB_OP = 3'h4;

    // ==========================================
    // Register map.
    localparam logic [7:0] CTRL_OFF = 8'h00;
    localparam logic [7:0] STAT_OFF = 8'h04;
    localparam logic [7:0] INPUT_OFF = 8'h08;
    localparam logic [31:0] CTRL_RST = 32'h0000_0000;
    localparam int CTRL_DIAG_BIT = 0;
    localparam int STAT_RUN_BIT = 0;
    localparam int STAT_ERR_BIT = 1;
    localparam int STAT_INP_BIT = 2;
    localparam int STAT_OUTP_BIT = 3;
    localparam int STAT_DIAG_BIT = 4;
    localparam int STAT_CSUP_BIT = 6;
    localparam int STAT_OSUP_BIT = 8;
    localparam int IN_WIDTH = 17;

endpackage : sli_pkg

// File: logic/sli_sync.sv
`timescale 1ns/10ps
module sli_sync #(
    parameter int WIDTH = 1
) (
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic [WIDTH-1:0] asyncIn,
    output logic [WIDTH-1:0] syncOut
);

    // ==========================================
    // Two-stage synchroniser for pin inputs.
    logic [WIDTH-1:0] meta_q;

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            meta_q <= '0;
            syncOut <= '0;
        end else begin
            meta_q <= asyncIn;
            syncOut <= meta_q;
        end
    end

endmodule : sli_sync

// File: logic/sli_pattern_gen.sv
`timescale 1ns/10ps
module sli_pattern_gen #(
    parameter int PHASE_CYC = sli_pkg::PHASE_CYC,
    parameter int FLICK_CYC = sli_pkg::FLICK_CYC
) (
    input wire logic sys_clk,
    input wire logic srst,
    output logic blink,
    output logic single,
    output logic double,
    output logic flicker
);

    // ==========================================
    // Time base: one tick per 0.2 s slot, one per flicker half period.
    logic [31:0] phaseCnt_q;
    logic [31:0] flickCnt_q;
    logic [3:0] slot6_q;
    logic [3:0] slot8_q;
    logic phaseTick;
    logic flickTick;

    assign phaseTick = (phaseCnt_q == 32'(PHASE_CYC - 1));
    assign flickTick = (flickCnt_q == 32'(FLICK_CYC - 1));

    always_ff @(posedge sys_clk) begin
        if (srst || phaseTick) begin
            phaseCnt_q <= 32'h0000_0000;
        end else begin
            phaseCnt_q <= phaseCnt_q + 32'h0000_0001;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst || flickTick) begin
            flickCnt_q <= 32'h0000_0000;
        end else begin
            flickCnt_q <= flickCnt_q + 32'h0000_0001;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            slot6_q <= 4'h0;
            slot8_q <= 4'h0;
        end else if (phaseTick) begin
            slot6_q <= (slot6_q == 4'(sli_pkg::SINGLE_SLOTS - 1)) ? 4'h0 : slot6_q + 4'h1;
            slot8_q <= (slot8_q == 4'(sli_pkg::DOUBLE_SLOTS - 1)) ? 4'h0 : slot8_q + 4'h1;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            blink <= 1'b1;
        end else if (phaseTick) begin
            blink <= ~blink;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            flicker <= 1'b1;
        end else if (flickTick) begin
            flicker <= ~flicker;
        end
    end

    // Single flash lights slot 0; double flash lights slots 0 and 2.
    assign single = (slot6_q == 4'h0);
    assign double = (slot8_q == 4'h0) || (slot8_q == 4'h2);

    // ==========================================
    // Checks.
    AST_BLINK_SLOT: assert property (@(posedge sys_clk) disable iff (srst)
        !phaseTick |=> $stable(blink))
        else $error("blink changed inside a slot");
    AST_FLICK_SLOT: assert property (@(posedge sys_clk) disable iff (srst)
        !flickTick |=> $stable(flicker))
        else $error("flicker changed inside its half period");
    AST_DOUBLE_GAP: assert property (@(posedge sys_clk) disable iff (srst)
        (phaseTick && slot8_q == 4'h2) |=> !double)
        else $error("double flash did not enter its pause");
    COV_DOUBLE_WRAP: cover property (@(posedge sys_clk) disable iff (srst)
        phaseTick && slot8_q == 4'h7);

endmodule : sli_pattern_gen

// File: logic/sli_status_led.sv
`timescale 1ns/10ps
// Contract
// - Run LED: off INIT, blink PREOP, single SAFEOP, flicker BOOT, steady OP.
// - Error LED: off normally, blink bad config, single flash sync/data error.
// - Error LED double flash on application watchdog timeout.
// - Input port LED: off no link, steady link idle, flicker with traffic.
// - Output port LED uses same encoding from downstream port status.
// - Unit diag LED steady green normally, green flashing on I/O unit error.
// - With diagnostics enabled, valve counter or coil fault flashes unit LED red.
// - Unit link failure alternates unit LED red and green.
// - Unit LED off without control supply, steady red on unit failure.
// - Control supply LED green when good, red when low and diagnostics on.
// - Output supply LED green when good; low: red if diagnostics on, else off.
// - Blink 0.2/0.2 s; single 0.2 on 1 off; double two 0.2 flashes, 1 off.
module sli_status_led #(
    parameter int PHASE_CYC = sli_pkg::PHASE_CYC,
    parameter int FLICK_CYC = sli_pkg::FLICK_CYC
) (
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    input wire logic [2:0] fbState,
    input wire logic cfgErr,
    input wire logic syncErr,
    input wire logic wdogErr,
    input wire logic inLink,
    input wire logic inAct,
    input wire logic outLink,
    input wire logic outAct,
    input wire logic ioDiagErr,
    input wire logic valveCntErr,
    input wire logic valveCoilErr,
    input wire logic unitLinkErr,
    input wire logic unitFail,
    input wire logic ctrlSupplyOk,
    input wire logic outSupplyOk,
    output logic runLed,
    output logic errLed,
    output logic inPortLinkLed,
    output logic outPortLinkLed,
    output logic unitDiagLedRed,
    output logic unitDiagLedGreen,
    output logic controlSupplyLedRed,
    output logic controlSupplyLedGreen,
    output logic outputSupplyLedRed,
    output logic outputSupplyLedGreen
);

    // ==========================================
    // Port LED encoding shared by both ports.
    function automatic logic portLed(input logic link, input logic act, input logic flick);
        portLed = link && (!act || flick);
    endfunction : portLed

    // ==========================================
    // Pin synchronisation.
    logic [sli_pkg::IN_WIDTH-1:0] pinRaw;
    logic [sli_pkg::IN_WIDTH-1:0] pinSync;
    logic [2:0] stS;
    logic cfgErrS;
    logic syncErrS;
    logic wdogErrS;
    logic inLinkS;
    logic inActS;
    logic outLinkS;
    logic outActS;
    logic ioDiagS;
    logic valveCntS;
    logic valveCoilS;
    logic unitLinkS;
    logic unitFailS;
    logic ctrlOkS;
    logic outOkS;

    assign pinRaw = {fbState, cfgErr, syncErr, wdogErr, inLink, inAct, outLink, outAct,
                     ioDiagErr, valveCntErr, valveCoilErr, unitLinkErr, unitFail,
                     ctrlSupplyOk, outSupplyOk};
    assign {stS, cfgErrS, syncErrS, wdogErrS, inLinkS, inActS, outLinkS, outActS,
            ioDiagS, valveCntS, valveCoilS, unitLinkS, unitFailS, ctrlOkS, outOkS} = pinSync;

    sli_sync #(
        .WIDTH(sli_pkg::IN_WIDTH)
    ) uSync (
        .sys_clk(sys_clk),
        .srst(srst),
        .asyncIn(pinRaw),
        .syncOut(pinSync)
    );

    // ==========================================
    // Pattern time base.
    logic blink;
    logic single;
    logic double;
    logic flicker;

    sli_pattern_gen #(
        .PHASE_CYC(PHASE_CYC),
        .FLICK_CYC(FLICK_CYC)
    ) uPattern (
        .sys_clk(sys_clk),
        .srst(srst),
        .blink(blink),
        .single(single),
        .double(double),
        .flicker(flicker)
    );

    // ==========================================
    // AHB-Lite slave, zero wait states, always OKAY.
    logic [31:0] ctrl_q;
    logic [31:0] rdMux;
    logic [31:0] statWord;
    logic wrPend_q;
    logic [7:0] wrAddr_q;
    logic addrPhase;
    logic diagEn;

    assign addrPhase = hsel && htrans[1] && hready;
    assign diagEn = ctrl_q[sli_pkg::CTRL_DIAG_BIT];

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            wrPend_q <= 1'b0;
            wrAddr_q <= 8'h00;
        end else begin
            wrPend_q <= addrPhase && hwrite;
            wrAddr_q <= haddr[7:0];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            ctrl_q <= sli_pkg::CTRL_RST;
        end else if (wrPend_q && wrAddr_q == sli_pkg::CTRL_OFF) begin
            ctrl_q <= {31'h0000_0000, hwdata[sli_pkg::CTRL_DIAG_BIT]};
        end
    end

    always_comb begin
        statWord = 32'h0000_0000;
        statWord[sli_pkg::STAT_RUN_BIT] = runLed;
        statWord[sli_pkg::STAT_ERR_BIT] = errLed;
        statWord[sli_pkg::STAT_INP_BIT] = inPortLinkLed;
        statWord[sli_pkg::STAT_OUTP_BIT] = outPortLinkLed;
        statWord[sli_pkg::STAT_DIAG_BIT+1:sli_pkg::STAT_DIAG_BIT] = {unitDiagLedGreen, unitDiagLedRed};
        statWord[sli_pkg::STAT_CSUP_BIT+1:sli_pkg::STAT_CSUP_BIT] =
            {controlSupplyLedGreen, controlSupplyLedRed};
        statWord[sli_pkg::STAT_OSUP_BIT+1:sli_pkg::STAT_OSUP_BIT] =
            {outputSupplyLedGreen, outputSupplyLedRed};
    end

    always_comb begin
        unique case (haddr[7:0])
            sli_pkg::CTRL_OFF: rdMux = ctrl_q;
            sli_pkg::STAT_OFF: rdMux = statWord;
            sli_pkg::INPUT_OFF: rdMux = {15'h0000, pinSync};
            default: rdMux = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            hrdata <= 32'h0000_0000;
        end else if (addrPhase && !hwrite) begin
            hrdata <= rdMux;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
    end

    // ==========================================
    // Run LED.
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            runLed <= 1'b0;
        end else begin
            unique case (stS)
                sli_pkg::FB_PREOP: runLed <= blink;
                sli_pkg::FB_SAFEOP: runLed <= single;
                sli_pkg::FB_BOOT: runLed <= flicker;
                sli_pkg::FB_OP: runLed <= 1'b1;
                default: runLed <= 1'b0;
            endcase
        end
    end

    // ==========================================
    // Error LED, watchdog loss ranks above sync and config errors.
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            errLed <= 1'b0;
        end else if (wdogErrS) begin
            errLed <= double;
        end else if (syncErrS) begin
            errLed <= single;
        end else if (cfgErrS) begin
            errLed <= blink;
        end else begin
            errLed <= 1'b0;
        end
    end

    // ==========================================
    // Port link/activity LEDs.
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            inPortLinkLed <= 1'b0;
            outPortLinkLed <= 1'b0;
        end else begin
            inPortLinkLed <= portLed(inLinkS, inActS, flicker);
            outPortLinkLed <= portLed(outLinkS, outActS, flicker);
        end
    end

    // ==========================================
    // Unit diagnostic LED.
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            unitDiagLedRed <= 1'b0;
            unitDiagLedGreen <= 1'b0;
        end else if (!ctrlOkS) begin
            unitDiagLedRed <= 1'b0;
            unitDiagLedGreen <= 1'b0;
        end else if (unitFailS) begin
            unitDiagLedRed <= 1'b1;
            unitDiagLedGreen <= 1'b0;
        end else if (unitLinkS) begin
            unitDiagLedRed <= blink;
            unitDiagLedGreen <= ~blink;
        end else if (diagEn && (valveCntS || valveCoilS)) begin
            unitDiagLedRed <= blink;
            unitDiagLedGreen <= 1'b0;
        end else if (ioDiagS) begin
            unitDiagLedRed <= 1'b0;
            unitDiagLedGreen <= blink;
        end else begin
            unitDiagLedRed <= 1'b0;
            unitDiagLedGreen <= 1'b1;
        end
    end

    // ==========================================
    // Supply LEDs.
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            controlSupplyLedRed <= 1'b0;
            controlSupplyLedGreen <= 1'b0;
        end else begin
            controlSupplyLedGreen <= ctrlOkS;
            controlSupplyLedRed <= !ctrlOkS && diagEn;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            outputSupplyLedRed <= 1'b0;
            outputSupplyLedGreen <= 1'b0;
        end else begin
            outputSupplyLedGreen <= outOkS;
            outputSupplyLedRed <= !outOkS && diagEn;
        end
    end

    // ==========================================
    // Checks.
    AST_RUN_INIT_OFF: assert property (@(posedge sys_clk) disable iff (srst)
        (stS == sli_pkg::FB_INIT) |=> !runLed)
        else $error("run LED lit in INIT");
    AST_RUN_FOLLOWS: assert property (@(posedge sys_clk) disable iff (srst)
        (stS == sli_pkg::FB_SAFEOP) |=> (runLed == $past(single)))
        else $error("run LED does not follow single flash in SAFEOP");
    AST_ERR_WDOG: assert property (@(posedge sys_clk) disable iff (srst)
        wdogErrS |=> (errLed == $past(double)))
        else $error("error LED not double flashing on watchdog loss");
    AST_ERR_SYNC: assert property (@(posedge sys_clk) disable iff (srst)
        (!wdogErrS && syncErrS) |=> (errLed == $past(single)))
        else $error("error LED not single flashing on sync error");
    AST_IN_IDLE: assert property (@(posedge sys_clk) disable iff (srst)
        (inLinkS && !inActS) |=> inPortLinkLed)
        else $error("input port LED dark on idle link");
    AST_OUT_NOLINK: assert property (@(posedge sys_clk) disable iff (srst)
        !outLinkS |=> !outPortLinkLed)
        else $error("output port LED lit without link");
    AST_DIAG_NOSUP: assert property (@(posedge sys_clk) disable iff (srst)
        !ctrlOkS |=> !unitDiagLedRed && !unitDiagLedGreen)
        else $error("unit LED lit without control supply");
    AST_DIAG_FAIL: assert property (@(posedge sys_clk) disable iff (srst)
        (ctrlOkS && unitFailS) |=> unitDiagLedRed && !unitDiagLedGreen)
        else $error("unit failure not steady red");
    AST_DIAG_ALT: assert property (@(posedge sys_clk) disable iff (srst)
        (ctrlOkS && !unitFailS && unitLinkS) |=> (unitDiagLedRed != unitDiagLedGreen))
        else $error("unit link error not alternating");
    AST_CSUP_LOW: assert property (@(posedge sys_clk) disable iff (srst)
        (!ctrlOkS && diagEn) |=> controlSupplyLedRed && !controlSupplyLedGreen)
        else $error("control supply low not red");
    AST_OSUP_QUIET: assert property (@(posedge sys_clk) disable iff (srst)
        (!outOkS && !diagEn) |=> !outputSupplyLedRed && !outputSupplyLedGreen)
        else $error("output supply low lit with diagnostics off");
    AST_OSUP_LOW: assert property (@(posedge sys_clk) disable iff (srst)
        (!outOkS && diagEn) |=> outputSupplyLedRed && !outputSupplyLedGreen)
        else $error("output supply low not red with diagnostics on");
    AST_RUN_OP: assert property (@(posedge sys_clk) disable iff (srst)
        (stS == sli_pkg::FB_OP) |=> runLed)
        else $error("run LED not steady in OP");
    AST_ERR_CFG: assert property (@(posedge sys_clk) disable iff (srst)
        (!wdogErrS && !syncErrS && cfgErrS) |=> (errLed == $past(blink)))
        else $error("error LED not blinking on bad configuration");
    AST_OUT_ACT: assert property (@(posedge sys_clk) disable iff (srst)
        (outLinkS && outActS) |=> (outPortLinkLed == $past(flicker)))
        else $error("output port LED not flickering with traffic");
    AST_DIAG_VALVE: assert property (@(posedge sys_clk) disable iff (srst)
        (ctrlOkS && !unitFailS && !unitLinkS && diagEn && (valveCntS || valveCoilS))
            |=> (unitDiagLedRed == $past(blink)) && !unitDiagLedGreen)
        else $error("valve fault not flashing unit LED red");
    AST_BUS_OKAY: assert property (@(posedge sys_clk) disable iff (srst)
        hreadyout && !hresp)
        else $error("bus answer not ready OKAY");
    COV_RUN_OP: cover property (@(posedge sys_clk) disable iff (srst)
        stS == sli_pkg::FB_OP ##1 runLed);
    COV_VALVE_RED: cover property (@(posedge sys_clk) disable iff (srst)
        diagEn && valveCntS && ctrlOkS ##1 unitDiagLedRed);
    COV_CTRL_WRITE: cover property (@(posedge sys_clk) disable iff (srst)
        wrPend_q && wrAddr_q == sli_pkg::CTRL_OFF);

endmodule : sli_status_led

// File: tb/sli_led_model.sv
`timescale 1ns/10ps
// ==========================================
// Front-panel LED model.
// Counts lit cycles and turn-ons per LED, and cycles with any red/green overlap on the three two-colour LEDs, over one window.
module sli_led_model (
    input wire logic sys_clk,
    input wire logic clr,
    input wire logic [9:0] led,
    output logic [15:0] litCnt_q [10],
    output logic [15:0] riseCnt_q [10],
    output logic [15:0] bothCnt_q
);
    logic [9:0] prevLed_q;

    always_ff @(posedge sys_clk) begin
        prevLed_q <= led;
        if (clr) begin
            bothCnt_q <= 16'h0000;
            for (int i = 0; i < 10; i++) begin
                litCnt_q[i] <= 16'h0000;
                riseCnt_q[i] <= 16'h0000;
            end
        end else begin
            bothCnt_q <= bothCnt_q + 16'((led[4] & led[5]) | (led[6] & led[7]) | (led[8] & led[9]));
            for (int i = 0; i < 10; i++) begin
                litCnt_q[i] <= litCnt_q[i] + 16'(led[i]);
                riseCnt_q[i] <= riseCnt_q[i] + 16'(led[i] & ~prevLed_q[i]);
            end
        end
    end
endmodule : sli_led_model

// File: tb/testbench.sv
`timescale 1ns/10ps
module testbench;
    // ==========================================
    // Signals and expected pattern figures.
    localparam int PH = 8;
    localparam int FL = 2;
    localparam int WIN = 192;
    localparam int OFF = 0, ON = 1, BLK = 2, SGL = 3, DBL = 4, FLK = 5;
    localparam int LIT_EXP [6] = '{0, WIN, WIN / 2, WIN / 6, WIN / 4, WIN / 2};
    localparam int RISE_EXP [6] = '{0, 0, WIN / (2 * PH), WIN / (6 * PH), 2 * WIN / (8 * PH), WIN / (2 * FL)};
    logic sys_clk, srst, hsel, hwrite, hreadyout, hresp, clr;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [16:0] pins;
    logic [9:0] led;
    logic [15:0] litCnt_q [10];
    logic [15:0] riseCnt_q [10];
    logic [15:0] bothCnt_q;
    int error_cnt = 0;
    int n_tests = 0;

    sli_status_led #(.PHASE_CYC(PH), .FLICK_CYC(FL)) i_dut (
        .sys_clk(sys_clk), .srst(srst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
        .fbState(pins[16:14]), .cfgErr(pins[13]), .syncErr(pins[12]), .wdogErr(pins[11]),
        .inLink(pins[10]), .inAct(pins[9]), .outLink(pins[8]), .outAct(pins[7]),
        .ioDiagErr(pins[6]), .valveCntErr(pins[5]), .valveCoilErr(pins[4]),
        .unitLinkErr(pins[3]), .unitFail(pins[2]), .ctrlSupplyOk(pins[1]), .outSupplyOk(pins[0]),
        .runLed(led[0]), .errLed(led[1]), .inPortLinkLed(led[2]), .outPortLinkLed(led[3]),
        .unitDiagLedRed(led[4]), .unitDiagLedGreen(led[5]),
        .controlSupplyLedRed(led[6]), .controlSupplyLedGreen(led[7]),
        .outputSupplyLedRed(led[8]), .outputSupplyLedGreen(led[9])
    );

    sli_led_model i_panel (
        .sys_clk(sys_clk), .clr(clr), .led(led),
        .litCnt_q(litCnt_q), .riseCnt_q(riseCnt_q), .bothCnt_q(bothCnt_q)
    );

    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end

    // ==========================================
    // Shared tasks.
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            error_cnt++;
            $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // One single-word transfer; entered just after a rising edge.
    task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] wd, output logic [31:0] rdv);
        int n;
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'b10;
        hwrite <= wr;
        hsize <= 3'h2;
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while (hreadyout !== 1'b1 && n < 100);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while (hreadyout !== 1'b1 && n < 100);
        rdv = hrdata;
    endtask : bus

    // Applies pins and the diagnostic enable, then checks every LED over one window.
    task automatic scen(input logic [16:0] p, input logic dEn, input int pat [10]);
        bus(1'b1, 32'(sli_pkg::CTRL_OFF), {31'h0, dEn}, rd);
        pins <= p;
        repeat (8) @(posedge sys_clk);
        bus(1'b0, 32'(sli_pkg::INPUT_OFF), 32'h0, rd);
        check(rd, {15'h0, p});
        clr <= 1'b1;
        @(posedge sys_clk);
        clr <= 1'b0;
        repeat (WIN) @(posedge sys_clk);
        #1;
        for (int i = 0; i < 10; i++) begin
            check(32'(litCnt_q[i]), 32'(LIT_EXP[pat[i]]));
            check(32'(riseCnt_q[i]), 32'(RISE_EXP[pat[i]]));
        end
        check(32'(bothCnt_q), 32'h0);
        @(posedge sys_clk);
        $display("test done: pins %h diag %b", p, dEn);
    endtask : scen

    task automatic print_verdict();
        $display("counts: %0d compares, %0d mismatches", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : print_verdict

    // ==========================================
    // Watchdog and main sequence.
    initial begin
        repeat (20000) @(posedge sys_clk);
        error_cnt++;
        $display("BAD t=%0t run did not finish", $time);
        print_verdict();
    end

    initial begin
        srst = 1'b1;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        pins = 17'h00000;
        clr = 1'b0;
        repeat (3) @(posedge sys_clk);
        check({20'h0, hresp, hreadyout, led}, {20'h0, 1'b0, 1'b1, 10'h000});
        srst <= 1'b0;
        @(posedge sys_clk);
        bus(1'b0, 32'(sli_pkg::CTRL_OFF), 32'h0, rd);
        check(rd, sli_pkg::CTRL_RST);
        bus(1'b1, 32'(sli_pkg::CTRL_OFF), 32'hFFFF_FFFF, rd);
        bus(1'b0, 32'(sli_pkg::CTRL_OFF), 32'h0, rd);
        check(rd, 32'h0000_0001);
        bus(1'b1, 32'h0000_000C, 32'hFFFF_FFFF, rd);
        bus(1'b0, 32'h0000_000C, 32'h0, rd);
        check(rd, 32'h0000_0000);
        bus(1'b1, 32'(sli_pkg::STAT_OFF), 32'hFFFF_FFFF, rd);
        bus(1'b0, 32'(sli_pkg::STAT_OFF), 32'h0, rd);
        check(rd, 32'h0000_0140);
        $display("test done: registers");
        scen({sli_pkg::FB_INIT, 14'h0003}, 1'b0, '{OFF, OFF, OFF, OFF, OFF, ON, OFF, ON, OFF, ON});
        scen({sli_pkg::FB_PREOP, 14'h2583}, 1'b0, '{BLK, BLK, ON, FLK, OFF, ON, OFF, ON, OFF, ON});
        scen({sli_pkg::FB_SAFEOP, 14'h3703}, 1'b0, '{SGL, SGL, FLK, ON, OFF, ON, OFF, ON, OFF, ON});
        scen({sli_pkg::FB_BOOT, 14'h1843}, 1'b0, '{FLK, DBL, OFF, OFF, OFF, BLK, OFF, ON, OFF, ON});
        scen({sli_pkg::FB_OP, 14'h0063}, 1'b1, '{ON, OFF, OFF, OFF, BLK, OFF, OFF, ON, OFF, ON});
        scen({sli_pkg::FB_OP, 14'h0013}, 1'b0, '{ON, OFF, OFF, OFF, OFF, ON, OFF, ON, OFF, ON});
        scen({sli_pkg::FB_OP, 14'h001B}, 1'b1, '{ON, OFF, OFF, OFF, BLK, BLK, OFF, ON, OFF, ON});
        scen({sli_pkg::FB_OP, 14'h000F}, 1'b1, '{ON, OFF, OFF, OFF, ON, OFF, OFF, ON, OFF, ON});
        scen({sli_pkg::FB_OP, 14'h0004}, 1'b1, '{ON, OFF, OFF, OFF, OFF, OFF, ON, OFF, ON, OFF});
        scen({3'h7, 14'h0002}, 1'b0, '{OFF, OFF, OFF, OFF, OFF, ON, OFF, ON, OFF, OFF});
        print_verdict();
    end
endmodule : testbench
